// ### rtl/rtc_defs.svh
// Constants for the real-time clock block: widths, field positions, reset values, timing.
// Assumes inclusion by bare name from rtl/; definitions only.
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

`define SEC_W              32
`define FRAC_W             12
`define DAYTIME_W          20
`define INTERVAL_W         32
`define TRIM_W             8
`define OSC_SETUP_W        8
`define RAW_WAVE_BIT       0
`define SEC_RST            32'h00000000
`define FRAC_RST           12'h000
`define DAYTIME_RST        20'h00000
`define INTERVAL_RST       32'h00000000
`define TRIM_RST           8'h00
`define OSC_SETUP_RST      8'h00
`define FRAC_ALL_ONES      12'hFFF
`define INTERVAL_ALL_ONES  32'hFFFFFFFF
`define OSC_LAST_NOMINAL   4'h7
`define OSC_LAST_FAST      4'h6
`define OSC_LAST_SLOW      4'h8
`define SQW_SEL_1HZ        2'h0
`define SQW_SEL_512HZ      2'h1
`define SQW_SEL_4KHZ       2'h2
`define SQW_1HZ_BIT        11
`define SQW_512HZ_BIT      2
`define RAW_4KHZ_BIT       2
`define BUSY_OSC_EDGES     2'h2
`define READY_WINDOW_US    120
`define CLK_PERIOD_NS      10

`endif

// ### rtl/rtc_pkg.sv
// Types shared by the real-time clock block.
// Assumes no other package.
package rtc_pkg;

  typedef struct packed {
    logic       run_enable;
    logic       free_read;
    logic       read_window_irq_on;
    logic       daytime_irq_on;
    logic       interval_irq_on;
    logic       wave_out_enable;
    logic [1:0] wave_rate_sel;
    logic       write_unlock;
  } ctrl_s;

  typedef struct packed {
    logic busy;
    logic read_window;
    logic daytime_flag;
    logic interval_flag;
  } status_s;

  typedef enum logic [3:0] {
    PM_RUN    = 4'h1,
    PM_SLEEP  = 4'h2,
    PM_DEEP   = 4'h4,
    PM_BACKUP = 4'h8
  } power_mode_e;

endpackage : rtc_pkg

// ### rtl/rtc_access_alarm_squarewave.sv
// Real-time clock core: counters, access gating, alarms, interrupt/wake, square wave.
// Assumes one 100 MHz clock; the 32.768 kHz oscillator arrives as an asynchronous pin.
// How it works
// - Fraction wrap advances the 32-bit seconds count
// - Run enable low freezes both counters
// - Read window flag high for 120 us
// - Free-read permit allows counter reads anytime
// - Read window rising raises interrupt when enabled
// - Synchronised writes hold busy until crossed
// - Trim and run enable need unlock; busy
// - Daytime alarm matches seconds bits 19..0
// - Daytime match sets flag once
// - Daytime flag requests interrupt when enabled
// - Interval enable loads counter, counts sub-seconds
// - Interval wrap sets flag and reloads
// - Later interval alarms recur exactly
// - Start value zero gives full count
// - Three enabled sources merge into interrupt
// - Alarms wake low-power modes when permitted
// - Square wave rates 1Hz/512Hz/4kHz or 32kHz
// - 1Hz and 512Hz follow trimmed clock
// - Counter writes need idle and read window
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_access_alarm_squarewave
  import rtc_pkg::*;
#(
  parameter int unsigned READY_WINDOW_CYCLES = `READY_WINDOW_US * 1000 / `CLK_PERIOD_NS,
  parameter int unsigned READY_CNT_W         = 14
) (
  input  wire logic                    mclk_in,
  input  wire logic                    rst_n_in,
  input  wire logic                    osc_32k_in,
  input  wire logic [31:0]             wdata_in,
  input  wire ctrl_s                   ctrl_wdata_in,
  input  wire logic                    sec_wr_in,
  input  wire logic                    frac_wr_in,
  input  wire logic                    daytime_alarm_wr_in,
  input  wire logic                    interval_alarm_wr_in,
  input  wire logic                    trim_wr_in,
  input  wire logic                    osc_setup_wr_in,
  input  wire logic                    ctrl_wr_in,
  input  wire logic                    read_window_clear_in,
  input  wire logic                    daytime_flag_set_in,
  input  wire logic                    daytime_flag_clear_in,
  input  wire logic                    interval_flag_clear_in,
  input  wire logic                    system_irq_enable_in,
  input  wire logic                    clock_wake_permit_in,
  input  wire power_mode_e             power_mode_in,
  output logic [`SEC_W-1:0]            sec_out,
  output logic [`FRAC_W-1:0]           frac_out,
  output logic [`DAYTIME_W-1:0]        daytime_alarm_reg_out,
  output logic [`INTERVAL_W-1:0]       interval_alarm_reg_out,
  output logic [`TRIM_W-1:0]           trim_out,
  output logic [`OSC_SETUP_W-1:0]      crystal_osc_setup_reg_out,
  output ctrl_s                        ctrl_out,
  output status_s                      status_out,
  output logic                         counter_read_ok_out,
  output logic                         irq_out,
  output logic                         wake_out,
  output logic                         calibration_wave_pin_out
);

  // ****************************************************************
  // Parameter checks
  // ****************************************************************
  if (READY_WINDOW_CYCLES < 1 || READY_WINDOW_CYCLES >= (64'd1 << READY_CNT_W)) begin : g_chk
    $error("READY_WINDOW_CYCLES does not fit READY_CNT_W");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                    osc_sync1_r;
  logic                    osc_sync2_r;
  logic                    osc_prev_r;
  logic [3:0]              presc_r;
  logic [2:0]              raw_div_r;
  logic [`TRIM_W-1:0]      trim_left_r;
  logic [`SEC_W-1:0]       sec_r;
  logic [`FRAC_W-1:0]      frac_r;
  logic [`DAYTIME_W-1:0]   daytime_r;
  logic [`INTERVAL_W-1:0]  interval_r;
  logic [`INTERVAL_W-1:0]  ivl_cnt_r;
  logic [`TRIM_W-1:0]      trim_r;
  logic [`OSC_SETUP_W-1:0] osc_setup_r;
  ctrl_s                   ctrl_r;
  logic                    ivl_on_d_r;
  logic                    busy_r;
  logic [1:0]              busy_cnt_r;
  logic                    rdy_r;
  logic [READY_CNT_W-1:0]  rdy_cnt_r;
  logic                    sec_step_r;
  logic                    day_flag_r;
  logic                    ivl_flag_r;
  logic                    irq_r;
  logic                    wake_r;
  logic                    wave_r;

  // ****************************************************************
  // Decode and selection
  // ****************************************************************
  wire        osc_edge     = osc_sync2_r & ~osc_prev_r;
  wire        trim_active  = (trim_left_r != `TRIM_W'(0));
  wire [3:0]  presc_last   = !trim_active ? `OSC_LAST_NOMINAL :
                             (trim_r[`TRIM_W-1] ? `OSC_LAST_SLOW : `OSC_LAST_FAST);
  wire        sub_tick     = osc_edge & ctrl_r.run_enable & (presc_r == presc_last);
  wire        frac_wrap    = sub_tick & (frac_r == `FRAC_ALL_ONES);
  wire [`TRIM_W-1:0] trim_abs = trim_r[`TRIM_W-1] ? `TRIM_W'(~trim_r + `TRIM_W'(1)) : trim_r;

  wire        cnt_wr_ok    = ~busy_r & rdy_r;
  wire        sec_wr_ok    = sec_wr_in & cnt_wr_ok;
  wire        frac_wr_ok   = frac_wr_in & cnt_wr_ok;
  wire        day_wr_ok    = daytime_alarm_wr_in & ~busy_r & ~ctrl_r.daytime_irq_on;
  wire        ivl_wr_ok    = interval_alarm_wr_in & ~busy_r & ~ctrl_r.interval_irq_on;
  wire        trim_wr_ok   = trim_wr_in & ~busy_r & ctrl_r.write_unlock;
  wire        osc_wr_ok    = osc_setup_wr_in & ctrl_r.write_unlock;
  wire        ctrl_wr_ok   = ctrl_wr_in & ~busy_r;
  wire        busy_set     = sec_wr_ok | frac_wr_ok | day_wr_ok | ivl_wr_ok | trim_wr_ok | ctrl_wr_ok;

  ctrl_s      ctrl_nxt;
  always_comb begin
    ctrl_nxt = ctrl_wdata_in;
    if (!ctrl_r.write_unlock) begin
      ctrl_nxt.run_enable = ctrl_r.run_enable;
    end
  end

  wire        ivl_start    = ctrl_r.interval_irq_on & ~ivl_on_d_r;
  wire        ivl_wrap     = ctrl_r.interval_irq_on & ~ivl_start & sub_tick &
                             (ivl_cnt_r == `INTERVAL_ALL_ONES);
  wire        day_match    = sec_step_r & (sec_r[`DAYTIME_W-1:0] == daytime_r);
  wire        rdy_done     = (rdy_cnt_r == READY_CNT_W'(READY_WINDOW_CYCLES - 1));

  wire        irq_nxt      = system_irq_enable_in &
                             ((day_flag_r & ctrl_r.daytime_irq_on) |
                              (ivl_flag_r & ctrl_r.interval_irq_on) |
                              (rdy_r & ctrl_r.read_window_irq_on));
  wire        low_power    = (power_mode_in == PM_SLEEP) | (power_mode_in == PM_DEEP) |
                             (power_mode_in == PM_BACKUP);
  wire        wake_nxt     = clock_wake_permit_in & low_power &
                             ((day_flag_r & ctrl_r.daytime_irq_on) |
                              (ivl_flag_r & ctrl_r.interval_irq_on));
  wire        wave_sel     = (ctrl_r.wave_rate_sel == `SQW_SEL_1HZ)   ? frac_r[`SQW_1HZ_BIT] :
                             (ctrl_r.wave_rate_sel == `SQW_SEL_512HZ) ? frac_r[`SQW_512HZ_BIT] :
                             (ctrl_r.wave_rate_sel == `SQW_SEL_4KHZ)  ? raw_div_r[`RAW_4KHZ_BIT] :
                             1'b0;
  wire        wave_nxt     = osc_setup_r[`RAW_WAVE_BIT] ? osc_sync2_r :
                             (ctrl_r.wave_out_enable & wave_sel);

  // ****************************************************************
  // Oscillator input and prescaler
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_sync1_r <= 1'b0;
      osc_sync2_r <= 1'b0;
      osc_prev_r  <= 1'b0;
    end else begin
      osc_sync1_r <= osc_32k_in;
      osc_sync2_r <= osc_sync1_r;
      osc_prev_r  <= osc_sync2_r;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      presc_r   <= 4'h0;
      raw_div_r <= 3'h0;
    end else if (osc_edge) begin
      raw_div_r <= raw_div_r + 3'h1;
      if (!ctrl_r.run_enable) begin
        presc_r <= presc_r;
      end else if (presc_r == presc_last) begin
        presc_r <= 4'h0;
      end else begin
        presc_r <= presc_r + 4'h1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trim_left_r <= `TRIM_RST;
    end else if (frac_wrap) begin
      trim_left_r <= trim_abs;
    end else if (sub_tick && trim_active) begin
      trim_left_r <= trim_left_r - `TRIM_W'(1);
    end
  end

  // ****************************************************************
  // Seconds and fraction counters
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frac_r <= `FRAC_RST;
    end else if (frac_wr_ok) begin
      frac_r <= wdata_in[`FRAC_W-1:0];
    end else if (sub_tick) begin
      frac_r <= frac_r + `FRAC_W'(1);
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sec_r      <= `SEC_RST;
      sec_step_r <= 1'b0;
    end else begin
      sec_step_r <= frac_wrap & ~sec_wr_ok;
      if (sec_wr_ok) begin
        sec_r <= wdata_in[`SEC_W-1:0];
      end else if (frac_wrap) begin
        sec_r <= sec_r + `SEC_W'(1);
      end
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      daytime_r   <= `DAYTIME_RST;
      interval_r  <= `INTERVAL_RST;
      trim_r      <= `TRIM_RST;
      osc_setup_r <= `OSC_SETUP_RST;
      ctrl_r      <= '0;
    end else begin
      if (day_wr_ok) begin
        daytime_r <= wdata_in[`DAYTIME_W-1:0];
      end
      if (ivl_wr_ok) begin
        interval_r <= wdata_in[`INTERVAL_W-1:0];
      end
      if (trim_wr_ok) begin
        trim_r <= wdata_in[`TRIM_W-1:0];
      end
      if (osc_wr_ok) begin
        osc_setup_r <= wdata_in[`OSC_SETUP_W-1:0];
      end
      if (ctrl_wr_ok) begin
        ctrl_r <= ctrl_nxt;
      end
    end
  end

  // ****************************************************************
  // Busy flag
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_r     <= 1'b0;
      busy_cnt_r <= 2'h0;
    end else if (busy_set) begin
      busy_r     <= 1'b1;
      busy_cnt_r <= 2'h0;
    end else if (busy_r && osc_edge) begin
      if (busy_cnt_r == `BUSY_OSC_EDGES - 2'h1) begin
        busy_r <= 1'b0;
      end
      busy_cnt_r <= busy_cnt_r + 2'h1;
    end
  end

  // ****************************************************************
  // Read window
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdy_r     <= 1'b0;
      rdy_cnt_r <= '0;
    end else if (sub_tick) begin
      rdy_r     <= 1'b1;
      rdy_cnt_r <= '0;
    end else if (read_window_clear_in) begin
      rdy_r <= 1'b0;
    end else if (rdy_r) begin
      if (rdy_done) begin
        rdy_r <= 1'b0;
      end
      rdy_cnt_r <= rdy_cnt_r + READY_CNT_W'(1);
    end
  end

  // ****************************************************************
  // Alarms
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      day_flag_r <= 1'b0;
    end else if (day_match || daytime_flag_set_in) begin
      day_flag_r <= 1'b1;
    end else if (daytime_flag_clear_in) begin
      day_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ivl_on_d_r <= 1'b0;
      ivl_cnt_r  <= `INTERVAL_RST;
      ivl_flag_r <= 1'b0;
    end else begin
      ivl_on_d_r <= ctrl_r.interval_irq_on;
      if (ivl_start || ivl_wrap) begin
        ivl_cnt_r <= interval_r;
      end else if (ctrl_r.interval_irq_on && sub_tick) begin
        ivl_cnt_r <= ivl_cnt_r + `INTERVAL_W'(1);
      end
      if (ivl_wrap) begin
        ivl_flag_r <= 1'b1;
      end else if (interval_flag_clear_in) begin
        ivl_flag_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt, wake and square wave outputs
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
      wave_r <= 1'b0;
    end else begin
      irq_r  <= irq_nxt;
      wake_r <= wake_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign sec_out                   = sec_r;
  assign frac_out                  = frac_r;
  assign daytime_alarm_reg_out     = daytime_r;
  assign interval_alarm_reg_out    = interval_r;
  assign trim_out                  = trim_r;
  assign crystal_osc_setup_reg_out = osc_setup_r;
  assign ctrl_out                  = ctrl_r;
  assign status_out                = '{busy: busy_r, read_window: rdy_r,
                                       daytime_flag: day_flag_r, interval_flag: ivl_flag_r};
  assign counter_read_ok_out       = ctrl_r.free_read | (rdy_r & ~busy_r);
  assign irq_out                   = irq_r;
  assign wake_out                  = wake_r;
  assign calibration_wave_pin_out  = wave_r;

endmodule : rtc_access_alarm_squarewave

`default_nettype wire

// ### tb/rtc_access_properties.sv
// Port-level checker for the real-time clock core.
// Assumes a bind onto rtc_access_alarm_squarewave and the rtl folder on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_defs.svh"

module rtc_access_properties
  import rtc_pkg::*;
#(
  parameter int unsigned READY_WINDOW_CYCLES = 12000
) (
  input wire logic                 mclk_in,
  input wire logic                 rst_n_in,
  input wire logic                 sec_wr_in,
  input wire logic                 frac_wr_in,
  input wire logic                 trim_wr_in,
  input wire logic                 read_window_clear_in,
  input wire logic                 system_irq_enable_in,
  input wire power_mode_e          power_mode_in,
  input wire logic [31:0]          wdata_in,
  input wire logic [`SEC_W-1:0]    sec_out,
  input wire logic [`FRAC_W-1:0]   frac_out,
  input wire logic [`TRIM_W-1:0]   trim_out,
  input wire ctrl_s                ctrl_out,
  input wire status_s              status_out,
  input wire logic                 irq_out,
  input wire logic                 wake_out
);
  // ****************************************
  // Read window length counter
  // ****************************************
  logic [15:0] run_len_r;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_len_r <= 16'h0000;
    end else begin
      run_len_r <= status_out.read_window ? run_len_r + 16'h0001 : 16'h0000;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  // ****************************************
  // Assertions
  // ****************************************
  frac_wrap_a: assert property (
    $past(frac_out) == `FRAC_ALL_ONES && frac_out == `FRAC_RST && !$past(frac_wr_in) && !$past(sec_wr_in)
    |-> sec_out == $past(sec_out) + 32'h1) else $error("seconds did not step on fraction wrap");
  run_freeze_a: assert property (
    !ctrl_out.run_enable && !frac_wr_in && !sec_wr_in |=> $stable(frac_out) && $stable(sec_out))
    else $error("counters moved while stopped");
  window_len_a: assert property (
    $fell(status_out.read_window) && !$past(read_window_clear_in)
    |-> {16'h0000, run_len_r} == READY_WINDOW_CYCLES) else $error("read window length wrong");
  window_irq_a: assert property (
    system_irq_enable_in && ctrl_out.read_window_irq_on && status_out.read_window |=> irq_out)
    else $error("read window interrupt missing");
  daytime_irq_a: assert property (
    system_irq_enable_in && ctrl_out.daytime_irq_on && status_out.daytime_flag |=> irq_out)
    else $error("daytime interrupt missing");
  irq_quiet_a: assert property (
    !system_irq_enable_in |=> !irq_out) else $error("interrupt while system enable low");
  sec_write_a: assert property (
    sec_wr_in && !status_out.busy && status_out.read_window
    |=> status_out.busy && sec_out == $past(wdata_in)) else $error("seconds write not taken");
  trim_lock_a: assert property (
    trim_wr_in && !ctrl_out.write_unlock |=> $stable(trim_out)) else $error("locked trim changed");
  wake_run_a: assert property (
    power_mode_in == PM_RUN |=> !wake_out) else $error("wake in run mode");

  cover property ($rose(irq_out));
  cover property ($fell(status_out.busy));
  cover property ($rose(status_out.interval_flag));
endmodule : rtc_access_properties

bind rtc_access_alarm_squarewave rtc_access_properties #(
  .READY_WINDOW_CYCLES(READY_WINDOW_CYCLES)
) chk_u (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .sec_wr_in(sec_wr_in), .frac_wr_in(frac_wr_in),
  .trim_wr_in(trim_wr_in), .read_window_clear_in(read_window_clear_in),
  .system_irq_enable_in(system_irq_enable_in), .power_mode_in(power_mode_in), .wdata_in(wdata_in),
  .sec_out(sec_out), .frac_out(frac_out), .trim_out(trim_out), .ctrl_out(ctrl_out),
  .status_out(status_out), .irq_out(irq_out), .wake_out(wake_out)
);

`default_nettype wire

// ### tb/rtc_access_alarm_squarewave_tb_top.sv
// Self-checking bench for the real-time clock core.
// Assumes a fast oscillator stand-in (8 clocks a period) and a 20-cycle read window.
`timescale 1ns/100ps
`default_nettype none

module rtc_access_alarm_squarewave_tb_top;
  import rtc_pkg::*;
  localparam int CTRL = 0, OSCW = 1, TRIM = 2, INTV = 3, DAY = 4, FRAC = 5, SEC = 6;
  localparam int RWCLR = 7, DSET = 8, DCLR = 9, ICLR = 10;
  logic        mclk_in = 1'b0, rst_n_in = 1'b0, osc_32k_in = 1'b0;
  logic        system_irq_enable_in = 1'b0, clock_wake_permit_in = 1'b0;
  logic [31:0] wdata_in = 32'h0, sec_out, interval_alarm_reg_out, s;
  logic [10:0] stb = 11'h000;
  ctrl_s       ctrl_wdata_in = '0, cfg = '0, ctrl_out;
  power_mode_e power_mode_in = PM_RUN;
  status_s     status_out;
  logic [11:0] frac_out;
  logic [19:0] daytime_alarm_reg_out;
  logic [7:0]  trim_out, crystal_osc_setup_reg_out;
  logic        counter_read_ok_out, irq_out, wake_out, calibration_wave_pin_out;
  int          n_fail = 0, total_checks = 0, cyc = 0, rises = 0, t1;

  always #5 mclk_in = ~mclk_in;
  always #40 osc_32k_in = ~osc_32k_in;
  always @(posedge mclk_in) cyc <= cyc + 1;
  always @(posedge calibration_wave_pin_out) rises++;

  rtc_access_alarm_squarewave #(.READY_WINDOW_CYCLES(20)) dut_u (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .osc_32k_in(osc_32k_in), .wdata_in(wdata_in),
    .ctrl_wdata_in(ctrl_wdata_in), .sec_wr_in(stb[SEC]), .frac_wr_in(stb[FRAC]),
    .daytime_alarm_wr_in(stb[DAY]), .interval_alarm_wr_in(stb[INTV]), .trim_wr_in(stb[TRIM]),
    .osc_setup_wr_in(stb[OSCW]), .ctrl_wr_in(stb[CTRL]), .read_window_clear_in(stb[RWCLR]),
    .daytime_flag_set_in(stb[DSET]), .daytime_flag_clear_in(stb[DCLR]),
    .interval_flag_clear_in(stb[ICLR]), .system_irq_enable_in(system_irq_enable_in),
    .clock_wake_permit_in(clock_wake_permit_in), .power_mode_in(power_mode_in),
    .sec_out(sec_out), .frac_out(frac_out), .daytime_alarm_reg_out(daytime_alarm_reg_out),
    .interval_alarm_reg_out(interval_alarm_reg_out), .trim_out(trim_out),
    .crystal_osc_setup_reg_out(crystal_osc_setup_reg_out), .ctrl_out(ctrl_out),
    .status_out(status_out), .counter_read_ok_out(counter_read_ok_out), .irq_out(irq_out),
    .wake_out(wake_out), .calibration_wave_pin_out(calibration_wave_pin_out)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic wait_st(input logic [3:0] m, input logic [3:0] v);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(posedge mclk_in);
      #1;
      if ((4'(status_out) & m) === v) break;
    end
    check({31'h0, k < 3000}, 32'h1, "wait bound");
  endtask : wait_st

  task automatic wr(input int idx, input logic [31:0] d);
    @(posedge mclk_in);
    wdata_in      <= d;
    ctrl_wdata_in <= cfg;
    stb           <= 11'h001 << idx;
    @(posedge mclk_in);
    stb <= 11'h000;
    #1;
  endtask : wr

  task automatic wave(input logic [1:0] sel, input logic [31:0] raw, input int lo, input int hi);
    cfg.wave_out_enable = 1'b1;
    cfg.wave_rate_sel   = sel;
    wr(CTRL, 32'h0);
    wait_st(4'h8, 4'h0);
    wr(OSCW, raw);
    rises = 0;
    repeat (640) @(posedge mclk_in);
    #1;
    check({31'h0, rises >= lo && rises <= hi}, 32'h1, "wave rate");
  endtask : wave

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    #300000;
    n_fail++;
    $display("mismatch at %0t: watchdog expired", $time);
    final_report();
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    void'($urandom(32'hFC41));
    repeat (20) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(posedge mclk_in);
    #1;
    check({9'h000, ctrl_out, status_out, irq_out, wake_out, trim_out}, 32'h0, "reset values");
    $display("test reset done");
    cfg.run_enable = 1'b1;
    wr(CTRL, 32'h0);
    check({31'h0, ctrl_out.run_enable}, 32'h0, "enable locked");
    check({31'h0, status_out.busy}, 32'h1, "busy after write");
    wait_st(4'h8, 4'h0);
    wr(TRIM, $urandom);
    check({24'h0, trim_out}, 32'h0, "trim locked");
    cfg = '0;
    cfg.write_unlock = 1'b1;
    wr(CTRL, 32'h0);
    wait_st(4'h8, 4'h0);
    check({20'h0, frac_out}, 32'h0, "frozen fraction");
    cfg.run_enable = 1'b1;
    cfg.read_window_irq_on = 1'b1;
    @(posedge mclk_in);
    system_irq_enable_in <= 1'b1;
    wr(CTRL, 32'h0);
    check({31'h0, ctrl_out.run_enable}, 32'h1, "enable unlocked");
    wait_st(4'h8, 4'h0);
    wr(TRIM, 32'h5A);
    check({24'h0, trim_out}, 32'h5A, "trim unlocked");
    wait_st(4'h8, 4'h0);
    wr(TRIM, 32'h0);
    wait_st(4'h8, 4'h0);
    s = $urandom & 32'hFE;
    wr(OSCW, s);
    check({24'h0, crystal_osc_setup_reg_out}, s, "osc setup");
    check({31'h0, status_out.busy}, 32'h0, "osc setup no busy");
    $display("test access done");
    wait_st(4'hC, 4'h4);
    check({31'h0, counter_read_ok_out}, 32'h1, "read ok");
    @(posedge mclk_in);
    #1;
    check({31'h0, irq_out}, 32'h1, "window irq");
    wr(RWCLR, 32'h0);
    check({31'h0, status_out.read_window}, 32'h0, "window cleared");
    wait_st(4'hC, 4'h4);
    cfg.read_window_irq_on = 1'b0;
    cfg.free_read = 1'b1;
    wr(CTRL, 32'h0);
    check({31'h0, counter_read_ok_out}, 32'h1, "free read");
    s = sec_out;
    @(posedge mclk_in);
    #1;
    check(sec_out, s, "repeat read");
    wait_st(4'h8, 4'h0);
    $display("test window done");
    s = $urandom;
    wr(DAY, s + 32'h1);
    check({12'h000, daytime_alarm_reg_out}, (s + 32'h1) & 32'h000FFFFF, "daytime reg");
    wait_st(4'h8, 4'h0);
    cfg.daytime_irq_on = 1'b1;
    wr(CTRL, 32'h0);
    wait_st(4'hC, 4'h4);
    wr(SEC, s);
    check(sec_out, s, "seconds write");
    wr(FRAC, 32'hFFE);
    check({31'h0, frac_out === 12'hFFE}, 32'h0, "busy write ignored");
    wait_st(4'hC, 4'h4);
    wr(FRAC, 32'hFFE);
    check({20'h0, frac_out}, 32'hFFE, "fraction write");
    wait_st(4'h2, 4'h2);
    check(sec_out, s + 32'h1, "seconds step");
    @(posedge mclk_in);
    #1;
    check({31'h0, irq_out}, 32'h1, "daytime irq");
    wr(DCLR, 32'h0);
    repeat (200) @(posedge mclk_in);
    #1;
    check({31'h0, status_out.daytime_flag}, 32'h0, "single event");
    wr(DSET, 32'h0);
    @(posedge mclk_in);
    #1;
    check({30'h0, status_out.daytime_flag, irq_out}, 32'h3, "software set irq");
    wr(DCLR, 32'h0);
    cfg.daytime_irq_on = 1'b0;
    wr(CTRL, 32'h0);
    wait_st(4'h8, 4'h0);
    $display("test daytime done");
    wr(INTV, 32'hFFFFFFFE);
    check(interval_alarm_reg_out, 32'hFFFFFFFE, "interval reg");
    wait_st(4'h8, 4'h0);
    cfg.interval_irq_on = 1'b1;
    wr(CTRL, 32'h0);
    wait_st(4'h1, 4'h1);
    t1 = cyc;
    @(posedge mclk_in);
    power_mode_in        <= PM_SLEEP;
    clock_wake_permit_in <= 1'b1;
    wr(ICLR, 32'h0);
    wait_st(4'h1, 4'h1);
    check(32'(cyc - t1), 32'h80, "interval period");
    @(posedge mclk_in);
    #1;
    check({31'h0, wake_out}, 32'h1, "wake");
    power_mode_in <= PM_RUN;
    $display("test interval done");
    wave(2'h2, 32'h0, 9, 11);
    wave(2'h3, 32'h0, 0, 0);
    wave(2'h1, 32'h0, 1, 2);
    wave(2'h2, 32'h1, 79, 81);
    $display("test wave done");
    cfg.run_enable = 1'b0;
    wr(CTRL, 32'h0);
    wait_st(4'h8, 4'h0);
    s = {20'h0, frac_out};
    repeat (200) @(posedge mclk_in);
    #1;
    check({20'h0, frac_out}, s, "stopped counters");
    $display("test freeze done");
    final_report();
  end
endmodule : rtc_access_alarm_squarewave_tb_top

`default_nettype wire
